// [fmr_host_model.sv]
// host-side model driving the serial programming pins, trigger pin and ramp enable
`timescale 1ns/100ps
module fmr_host_model (
   // clock
   input wire logic clk_sys,
   // serial programming pins
   output logic ser_clk,
   output logic ser_data,
   output logic ser_le,
   // trigger pin and ramp enable bit
   output logic trig_pin,
   output logic ramp_enable
);
   // idle levels from time zero, serial clock parked low outside frames
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_le = 1'b0;
      trig_pin = 1'b0;
      ramp_enable = 1'b0;
   end
   ////////////////////////////////////////
   // all pin changes land on falling edges; 4 cycles per level clears the synchronisers
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic send_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         wait_n(1);
         ser_data = w[i];
         wait_n(4);
         ser_clk = 1'b1;
         wait_n(4);
         ser_clk = 1'b0;
      end
      wait_n(4);
      ser_le = 1'b1;
      wait_n(4);
      ser_le = 1'b0;
      // data not held after the frame, so the last bit never lingers
      ser_data = ~w[0];
      wait_n(4);
   endtask
   task automatic toggle_trig();
      wait_n(1);
      trig_pin = ~trig_pin;
      wait_n(4);
   endtask
   task automatic toggle_en();
      wait_n(1);
      ramp_enable = ~ramp_enable;
      wait_n(4);
   endtask
endmodule

// [fmr_params.svh]
// constants for the ramp configuration block: control codes, field positions, resets
`ifndef FMR_PARAMS_SVH
`define FMR_PARAMS_SVH
// control field codes in the low five bits of each word
`define FMR_CTRL_MSB 4
`define FMR_CTRL_CLOCK 5'h0d
`define FMR_CTRL_DEV 5'h0e
`define FMR_CTRL_STEP 5'h0f
`define FMR_CTRL_DELAY 5'h10
`define FMR_CTRL_FIXED 5'h11
`define FMR_FIXED_WORD 32'h0000_0011
// clock register fields
`define FMR_CDM_MSB 20
`define FMR_CDM_LSB 19
`define FMR_TMR_MSB 18
`define FMR_TMR_LSB 7
`define FMR_CSEL_MSB 6
`define FMR_CSEL_LSB 5
// deviation register fields
`define FMR_INV_BIT 31
`define FMR_RCLK_BIT 30
`define FMR_DSEL_MSB 26
`define FMR_DSEL_LSB 25
`define FMR_DOFF_MSB 24
`define FMR_DOFF_LSB 21
`define FMR_DEV_MSB 20
`define FMR_DEV_LSB 5
// step register fields
`define FMR_SSEL_MSB 26
`define FMR_SSEL_LSB 25
`define FMR_STEP_MSB 22
`define FMR_STEP_LSB 3
// delay register fields
`define FMR_LSEL_MSB 24
`define FMR_LSEL_LSB 23
`define FMR_TRIG_BIT 20
`define FMR_RDLY_BIT 19
`define FMR_DLY_MSB 16
`define FMR_DLY_LSB 5
// reset values and fixed slot used for the between-ramp delay
`define FMR_MODE_RST 2'h0
`define FMR_WORD_RST 32'h0000_0000
`define FMR_DLY_SLOT 2'h0
`endif

// [fmr_pkg.sv]
// types shared by the ramp configuration block
package fmr_pkg;
   typedef enum logic [1:0] {
      fmr_idle = 2'b00,
      fmr_delay = 2'b01,
      fmr_run = 2'b10
   } fmr_state_t;
   typedef logic [1:0] fmr_slot_t;
endpackage

// [fmr_ramp_cfg.sv]
// ramp configuration registers with the ramp sequencer they steer
// How it works
// RQ1: host writes divider mode 11 when ramping, 00 otherwise.
// RQ2: clock register bits 18:7 give the segment step timer divider.
// RQ3: clock register bits 6:5 pick the segment slot for that divider.
// RQ4: control 01110 selects deviation, 01111 step, 10000 delay register.
// RQ5: deviation bit 31 picks rising or falling trigger edge.
// RQ6: deviation bit 30 clocks ramp from divider or trigger pin.
// RQ7: deviation bits 26:25 pick one of four deviation slots.
// RQ8: deviation bits 24:21 hold the offset scaling the step.
// RQ9: deviation bits 20:5 hold a signed 16-bit step size.
// RQ10: step register bits 26:25 pick one of four step slots.
// RQ11: step register bits 22:3 hold steps per segment.
// RQ12: delay register bits 24:23 pick the delay slot.
// RQ13: delay bit 20 enables trigger start, together with ramp enable.
// RQ14: trigger driver aligns edges to reference, pulses last four periods.
// RQ15: ramp starts or stops only on a trigger after enable toggles.
// RQ16: delay bit 19 inserts a delay between successive ramps.
// RQ17: delay bits 16:5 set the wait before a ramp starts.
// RQ18: host writes the fixed reserved register as 0x00000011.
// RQ19: host writes reserved bit ranges with their fixed values.
// RQ20: host follows the reset and counter start order, waits 10 us.
// RQ21: host runs frequency and channel calibrations in order, with waits.
// RQ22: host fills all four step, deviation and timer slots.
// RQ23: control 01101 selects the clock register.
// RQ24: words shift in serially, control field low, latched by load enable.
// RQ25: four slots per word kind, written only on matching select.
`timescale 1ns/100ps
`include "fmr_params.svh"
module fmr_ramp_cfg (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial programming pins
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_le,
   // trigger pin and ramp enable bit
   input wire logic trig_pin,
   input wire logic ramp_enable,
   // configuration and ramp state
   output logic [1:0] ramp_divider_mode,
   output logic ramp_active,
   output logic [1:0] ramp_segment,
   output logic [31:0] freq_offset,
   output logic fixed_word_ok
);
   // true when a latched word carries the given control code
   function automatic logic fmr_hit(input logic v, input logic [31:0] w, input logic [4:0] c);
      fmr_hit = v && (w[`FMR_CTRL_MSB:0] == c);
   endfunction

   logic [31:0] word;
   logic word_valid;
   logic we_clk, we_dev, we_step, we_dly;
   logic [11:0] timer_rd;
   logic [19:0] dev_rd;
   logic [19:0] step_rd;
   logic [11:0] dly_rd;

   ////////////////////////////////////////////////////////////////////////
   // serial receiver and slot stores
   fmr_serial_in u_serial (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .ser_clk(ser_clk),
      .ser_data(ser_data),
      .ser_le(ser_le),
      .word_q(word),
      .word_valid(word_valid)
   );

   // RQ23: clock register decode
   assign we_clk = fmr_hit(word_valid, word, `FMR_CTRL_CLOCK);
   // RQ4: ramp register decode
   assign we_dev = fmr_hit(word_valid, word, `FMR_CTRL_DEV);
   assign we_step = fmr_hit(word_valid, word, `FMR_CTRL_STEP);
   assign we_dly = fmr_hit(word_valid, word, `FMR_CTRL_DELAY);

   // RQ2: segment timer slots
   // RQ3: slot chosen by bits 6:5
   fmr_slot_mem #(.W(12)) u_timer (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .we(we_clk),
      .waddr(word[`FMR_CSEL_MSB:`FMR_CSEL_LSB]),
      .wdata(word[`FMR_TMR_MSB:`FMR_TMR_LSB]),
      .raddr(ramp_segment),
      .rdata_q(timer_rd)
   );

   // RQ7: deviation slot select
   // RQ8: offset kept above the word
   fmr_slot_mem #(.W(20)) u_dev (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .we(we_dev),
      .waddr(word[`FMR_DSEL_MSB:`FMR_DSEL_LSB]),
      .wdata({word[`FMR_DOFF_MSB:`FMR_DOFF_LSB], word[`FMR_DEV_MSB:`FMR_DEV_LSB]}),
      .raddr(ramp_segment),
      .rdata_q(dev_rd)
   );

   // RQ10: step slot select
   // RQ11: steps per segment
   fmr_slot_mem #(.W(20)) u_step (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .we(we_step),
      .waddr(word[`FMR_SSEL_MSB:`FMR_SSEL_LSB]),
      .wdata(word[`FMR_STEP_MSB:`FMR_STEP_LSB]),
      .raddr(ramp_segment),
      .rdata_q(step_rd)
   );

   // RQ12: delay slot select
   // RQ17: delay word store
   fmr_slot_mem #(.W(12)) u_delay (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .we(we_dly),
      .waddr(word[`FMR_LSEL_MSB:`FMR_LSEL_LSB]),
      .wdata(word[`FMR_DLY_MSB:`FMR_DLY_LSB]),
      .raddr(`FMR_DLY_SLOT),
      .rdata_q(dly_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // two-bit divider mode and single-bit configuration latched from the decoded words
   logic [1:0] mode_q, mode_d;
   logic inv_q, inv_d, rclk_q, rclk_d;
   logic trig_en_q, trig_en_d, dly_en_q, dly_en_d;
   logic fixed_q, fixed_d;

   always_comb begin
      mode_d = mode_q;
      inv_d = inv_q;
      rclk_d = rclk_q;
      trig_en_d = trig_en_q;
      dly_en_d = dly_en_q;
      fixed_d = fixed_q;
      // RQ1: mode kept as written
      if (we_clk) begin
         mode_d = word[`FMR_CDM_MSB:`FMR_CDM_LSB];
      end
      if (we_dev) begin
         inv_d = word[`FMR_INV_BIT];
         rclk_d = word[`FMR_RCLK_BIT];
      end
      if (we_dly) begin
         trig_en_d = word[`FMR_TRIG_BIT];
         dly_en_d = word[`FMR_RDLY_BIT];
      end
      // RQ18: flags a correct fixed word
      if (fmr_hit(word_valid, word, `FMR_CTRL_FIXED)) begin
         fixed_d = (word == `FMR_FIXED_WORD);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= `FMR_MODE_RST;
         inv_q <= 1'b0;
         rclk_q <= 1'b0;
         trig_en_q <= 1'b0;
         dly_en_q <= 1'b0;
         fixed_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         inv_q <= inv_d;
         rclk_q <= rclk_d;
         trig_en_q <= trig_en_d;
         dly_en_q <= dly_en_d;
         fixed_q <= fixed_d;
      end
   end

   assign ramp_divider_mode = mode_q;
   assign fixed_word_ok = fixed_q;

   ////////////////////////////////////////////////////////////////////////
   // ramp sequencer
   fmr_pkg::fmr_state_t state_q, state_d;
   logic trig1_q, trig2_q, trig3_q, ren_prev_q;
   logic arm_q, arm_d, disarm_q, disarm_d;
   logic [1:0] seg_q, seg_d, reload_q, reload_d;
   logic [11:0] div_q, div_d, dly_q, dly_d;
   logic [19:0] step_q, step_d;
   logic [31:0] acc_q, acc_d;
   logic trig_edge, div_tick, tick, start, stop, last_step;
   logic [31:0] dev_step;

   // RQ5: active trigger edge
   assign trig_edge = inv_q ? (trig3_q && !trig2_q) : (!trig3_q && trig2_q);
   // divider idles while slot data for a new segment is still in flight
   assign div_tick = (reload_q == 2'h0) && (div_q <= 12'h001);
   // RQ6: ramp clock source
   assign tick = (reload_q == 2'h0) && (rclk_q ? trig_edge : div_tick);
   // RQ13: trigger start gate
   // RQ15: armed by enable rise
   assign start = trig_en_q && ramp_enable && arm_q && trig_edge;
   assign stop = trig_en_q && disarm_q && trig_edge;
   // RQ11: segment length check
   assign last_step = (step_q + 20'h00001) >= step_rd;
   // RQ9: signed step scaled by offset
   assign dev_step = {{16{dev_rd[15]}}, dev_rd[15:0]} << dev_rd[19:16];

   always_comb begin
      state_d = state_q;
      // set wins over the clear taken below
      arm_d = arm_q;
      disarm_d = disarm_q;
      seg_d = seg_q;
      reload_d = {reload_q[0], 1'b0};
      div_d = div_q;
      dly_d = dly_q;
      step_d = step_q;
      acc_d = acc_q;
      // RQ2: divider paces steps
      if (state_q != fmr_pkg::fmr_idle) begin
         if (reload_q[1]) begin
            div_d = timer_rd;
         end else if (div_tick) begin
            div_d = timer_rd;
         end else begin
            div_d = div_q - 12'h001;
         end
      end
      unique case (state_q)
         fmr_pkg::fmr_idle: begin
            if (start) begin
               arm_d = 1'b0;
               disarm_d = 1'b0;
               seg_d = 2'h0;
               step_d = 20'h00000;
               acc_d = `FMR_WORD_RST;
               reload_d = 2'h1;
               dly_d = dly_rd;
               // RQ16: optional lead delay
               state_d = dly_en_q ? fmr_pkg::fmr_delay : fmr_pkg::fmr_run;
            end
         end
         fmr_pkg::fmr_delay: begin
            if (stop) begin
               disarm_d = 1'b0;
               state_d = fmr_pkg::fmr_idle;
            end else if (tick) begin
               // RQ17: delay countdown
               if (dly_q <= 12'h001) begin
                  state_d = fmr_pkg::fmr_run;
               end else begin
                  dly_d = dly_q - 12'h001;
               end
            end
         end
         fmr_pkg::fmr_run: begin
            if (stop) begin
               disarm_d = 1'b0;
               state_d = fmr_pkg::fmr_idle;
            end else if (tick) begin
               acc_d = acc_q + dev_step;
               if (last_step) begin
                  step_d = 20'h00000;
                  seg_d = seg_q + 2'h1;
                  reload_d = 2'h1;
                  // RQ16: delay between ramps
                  if (seg_q == 2'h3 && dly_en_q) begin
                     dly_d = dly_rd;
                     state_d = fmr_pkg::fmr_delay;
                  end
               end else begin
                  step_d = step_q + 20'h00001;
               end
            end
         end
         default: begin
            state_d = fmr_pkg::fmr_idle;
         end
      endcase
      // RQ15: enable edges arm start and stop
      if (ramp_enable && !ren_prev_q) begin
         arm_d = 1'b1;
      end
      if (!ramp_enable && ren_prev_q) begin
         disarm_d = 1'b1;
      end
   end

   // trigger pin passes two flops before the edge detector
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trig1_q <= 1'b0;
         trig2_q <= 1'b0;
         trig3_q <= 1'b0;
         ren_prev_q <= 1'b0;
         state_q <= fmr_pkg::fmr_idle;
         arm_q <= 1'b0;
         disarm_q <= 1'b0;
         seg_q <= 2'h0;
         reload_q <= 2'h0;
         div_q <= 12'h000;
         dly_q <= 12'h000;
         step_q <= 20'h00000;
         acc_q <= `FMR_WORD_RST;
      end else begin
         trig1_q <= trig_pin;
         trig2_q <= trig1_q;
         trig3_q <= trig2_q;
         ren_prev_q <= ramp_enable;
         state_q <= state_d;
         arm_q <= arm_d;
         disarm_q <= disarm_d;
         seg_q <= seg_d;
         reload_q <= reload_d;
         div_q <= div_d;
         dly_q <= dly_d;
         step_q <= step_d;
         acc_q <= acc_d;
      end
   end

   assign ramp_active = (state_q != fmr_pkg::fmr_idle);
   assign ramp_segment = seg_q;
   assign freq_offset = acc_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_seg_end;
      (state_q == fmr_pkg::fmr_run) && tick && !stop && last_step;
   endsequence
   sequence s_no_delay_end;
      s_seg_end ##0 (seg_q == 2'h3) && !dly_en_q;
   endsequence

   a_mode_store: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ23
      we_clk |=> ramp_divider_mode == $past(word[`FMR_CDM_MSB:`FMR_CDM_LSB]))
      else $error("divider mode not taken from clock word");
   a_start_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ13
      (state_q == fmr_pkg::fmr_idle) ##1 (state_q != fmr_pkg::fmr_idle)
      |-> $past(trig_en_q && ramp_enable && arm_q && trig_edge))
      else $error("ramp started without armed trigger");
   a_stop_trigger: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ15
      ramp_active ##1 !ramp_active |-> $past(disarm_q && trig_edge))
      else $error("ramp stopped without trigger after disable");
   a_edge_polarity: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ5
      trig_edge |-> (inv_q ? $fell(trig2_q) : $rose(trig2_q)))
      else $error("trigger acted on the wrong edge");
   a_seg_advance: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ11
      s_seg_end |=> seg_q == $past(seg_q) + 2'h1 && step_q == 20'h00000 ##2 reload_q == 2'h0)
      else $error("segment did not advance after its last step");
   a_no_delay: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ16
      s_no_delay_end |=> state_q == fmr_pkg::fmr_run)
      else $error("delay inserted while disabled");
   a_acc_step: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ9
      ((state_q == fmr_pkg::fmr_run) && tick && !stop) |=> acc_q == $past(acc_q + dev_step))
      else $error("offset did not move by one scaled step");
   a_clock_source: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ6
      (rclk_q && state_q == fmr_pkg::fmr_run && $changed(acc_q)) |-> $past(trig_edge))
      else $error("ramp stepped without a trigger edge");
endmodule

// [fmr_serial_in.sv]
// serial word receiver: pin synchronisers, shifter and load strobe
`timescale 1ns/100ps
`include "fmr_params.svh"
module fmr_serial_in (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial pins
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_le,
   // received word
   output logic [31:0] word_q,
   output logic word_valid
);
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [1:0] prev_q;
   logic [31:0] shift_q;
   logic [31:0] shift_d;
   logic [31:0] word_d;
   logic valid_q;
   logic valid_d;

   ////////////////////////////////////////////////////////////////////////
   // next values: shift on serial clock rise, latch on load-enable rise
   always_comb begin
      shift_d = shift_q;
      word_d = word_q;
      valid_d = 1'b0;
      // RQ24: shift and latch
      if (sync2_q[0] && !prev_q[0]) begin
         shift_d = {shift_q[30:0], sync2_q[1]};
      end
      if (sync2_q[2] && !prev_q[1]) begin
         word_d = shift_q;
         valid_d = 1'b1;
      end
   end

   // pins pass two flops; data and clock share latency so they stay aligned
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         prev_q <= 2'h0;
         shift_q <= `FMR_WORD_RST;
         word_q <= `FMR_WORD_RST;
         valid_q <= 1'b0;
      end else begin
         sync1_q <= {ser_le, ser_data, ser_clk};
         sync2_q <= sync1_q;
         prev_q <= {sync2_q[2], sync2_q[0]};
         shift_q <= shift_d;
         word_q <= word_d;
         valid_q <= valid_d;
      end
   end

   assign word_valid = valid_q;

   a_word_strobe: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ24
      (sync2_q[2] && !prev_q[1]) |=> (word_valid && word_q == $past(shift_q)) ##1 !word_valid)
      else $error("load strobe did not latch the shifted word");
endmodule

// [fmr_slot_mem.sv]
// four-slot word store with registered read data
`timescale 1ns/100ps
`include "fmr_params.svh"
module fmr_slot_mem #(
   parameter int W = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // write port
   input wire logic we,
   input wire fmr_pkg::fmr_slot_t waddr,
   input wire logic [W-1:0] wdata,
   // read port
   input wire fmr_pkg::fmr_slot_t raddr,
   output logic [W-1:0] rdata_q
);
   logic [W-1:0] mem_q [4];
   logic [W-1:0] mem_d [4];

   ////////////////////////////////////////////////////////////////////////
   // RQ25: slot write select
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         mem_d[i] = (we && waddr == 2'(i)) ? wdata : mem_q[i];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            mem_q[i] <= '0;
         end
         rdata_q <= '0;
      end else begin
         mem_q <= mem_d;
         rdata_q <= mem_q[raddr];
      end
   end

   a_slot_store: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ25
      (we && waddr == raddr) ##1 (!we && $stable(raddr)) |=> rdata_q == $past(wdata, 2))
      else $error("slot did not keep the written word");
endmodule

// [tb.sv]
// self-checking bench for the ramp configuration block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
   logic clk_sys;
   logic reset_n;
   logic ser_clk, ser_data, ser_le, trig_pin, ramp_enable;
   logic [1:0] ramp_divider_mode;
   logic ramp_active;
   logic [1:0] ramp_segment;
   logic [31:0] freq_offset;
   logic fixed_word_ok;
   int err_count = 0;
   int n_tests = 0;
   int seed = 83508;
   int steps[4];
   int devv[4];
   int offs[4];
   int exp_off, cur;
   logic [31:0] w, r, dev0;
   logic [31:0] boot[7] = '{32'h0200_0007, 32'h0000_002b, 32'h0000_000b, 32'h800f_e520,
      32'h800f_e720, 32'h800f_ed60, 32'h800f_f5a0};
   logic [31:0] fixw[3] = '{32'h0000_0011, 32'h0000_0031, 32'h0000_0011};
   logic fixe[3] = '{1'b1, 1'b0, 1'b1};
   ////////////////////////////////////////
   // 20 MHz system clock
   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;
   // design and host model
   fmr_ramp_cfg u_fmr_ramp_cfg (.clk_sys(clk_sys), .reset_n(reset_n),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le),
      .trig_pin(trig_pin), .ramp_enable(ramp_enable),
      .ramp_divider_mode(ramp_divider_mode), .ramp_active(ramp_active),
      .ramp_segment(ramp_segment), .freq_offset(freq_offset),
      .fixed_word_ok(fixed_word_ok));
   fmr_host_model u_fmr_host_model (.clk_sys(clk_sys), .ser_clk(ser_clk),
      .ser_data(ser_data), .ser_le(ser_le), .trig_pin(trig_pin),
      .ramp_enable(ramp_enable));
   ////////////////////////////////////////
   // verdict, shared by the main sequence and the watchdog
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic pulse();
      u_fmr_host_model.toggle_trig();
      u_fmr_host_model.toggle_trig();
   endtask
   // random settling gap after a pin change, never shorter than the sync latency
   task automatic settle();
      u_fmr_host_model.wait_n(4 + ($random(seed) & 3));
   endtask
   // bounded wait for the sequencer to leave segment cur
   task automatic next_seg();
      int c;
      c = 0;
      while (ramp_segment === 2'(cur) && c < 400) begin
         @(negedge clk_sys);
         c++;
      end
   endtask
   // watchdog: about 10400 cycles expected, a hang is cut well after that
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      end_sim();
   end
   ////////////////////////////////////////
   // main sequence
   initial begin
      reset_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      reset_n = 1'b1;
      `CHK(ramp_active, 1'b0)
      // start-up words, all foreign codes that must leave this block untouched
      for (int i = 0; i < 7; i++) begin
         u_fmr_host_model.send_word(boot[i]);
         u_fmr_host_model.wait_n(i == 3 ? 200 : 20);
      end
      `CHK(ramp_divider_mode, 2'h0)
      for (int i = 0; i < 3; i++) begin
         u_fmr_host_model.send_word(fixw[i]);
         `CHK(fixed_word_ok, fixe[i])
      end
      // fill step, deviation and timer slots with random contents
      for (int s = 0; s < 4; s++) begin
         r = $random(seed);
         w = {5'h0, 2'(s), 2'h0, 18'((s == 0) ? 1 : r[20]), 5'h0f};
         steps[s] = int'(w[22:3]);
         u_fmr_host_model.send_word(w);
         w = {5'h0, 2'(s), 2'h0, r[17:16], r[15:0], 5'h0e};
         if (s == 0) dev0 = w;
         offs[s] = int'(r[17:16]);
         devv[s] = {{16{r[15]}}, r[15:0]};
         u_fmr_host_model.send_word(w);
         w = {11'h0, 2'h3, 12'(3 + r[19:18]), 2'(s), 5'h0d};
         u_fmr_host_model.send_word(w);
      end
      // trigger enabled, random delay word and slot, no ramp delay
      r = $random(seed);
      w = (r & 32'h0181_ffe0) | 32'h0010_0010;
      u_fmr_host_model.send_word(w);
      `CHK(ramp_divider_mode, 2'h3)
      // unknown control code with a random payload is ignored
      w = {r[31:5], 5'h12};
      u_fmr_host_model.send_word(w);
      `CHK(ramp_divider_mode, 2'h3)
      // first ramp: every segment boundary and the wrap back to segment 0
      u_fmr_host_model.toggle_en();
      pulse();
      `CHK(ramp_active, 1'b1)
      exp_off = 0;
      cur = 0;
      for (int k = 0; k < 5; k++) begin
         next_seg();
         exp_off += steps[cur] * (devv[cur] <<< offs[cur]);
         `CHK(freq_offset, exp_off[31:0])
         `CHK(ramp_segment, 2'((cur + 1) % 4))
         `CHK(ramp_active, 1'b1)
         cur = (cur + 1) % 4;
      end
      // dropping enable alone keeps the ramp; the next trigger stops it
      u_fmr_host_model.toggle_en();
      `CHK(ramp_active, 1'b1)
      pulse();
      settle();
      `CHK(ramp_active, 1'b0)
      // lead delay of 40 ticks in slot 0; a write to another slot must not shorten it
      w = 32'h0018_0510;
      u_fmr_host_model.send_word(w);
      r = $random(seed);
      w = 32'h0018_0030 | {7'h0, r[1:0] | 2'h1, 23'h0};
      u_fmr_host_model.send_word(w);
      u_fmr_host_model.toggle_en();
      pulse();
      settle();
      `CHK(ramp_active, 1'b1)
      `CHK(freq_offset, 32'h0000_0000)
      exp_off = steps[0] * (devv[0] <<< offs[0]);
      cur = 0;
      next_seg();
      `CHK(freq_offset, exp_off[31:0])
      u_fmr_host_model.toggle_en();
      pulse();
      settle();
      `CHK(ramp_active, 1'b0)
      // trigger disabled in the delay register, random delay bits
      r = $random(seed);
      w = (r & 32'h0181_ffe0) | 32'h0000_0010;
      u_fmr_host_model.send_word(w);
      u_fmr_host_model.toggle_en();
      pulse();
      settle();
      `CHK(ramp_active, 1'b0)
      // inverted trigger: rising edge ignored, falling edge starts
      w = (r & 32'h0181_ffe0) | 32'h0010_0010;
      u_fmr_host_model.send_word(w);
      u_fmr_host_model.send_word(dev0 | 32'h8000_0000);
      u_fmr_host_model.toggle_en();
      u_fmr_host_model.toggle_en();
      u_fmr_host_model.toggle_trig();
      settle();
      `CHK(ramp_active, 1'b0)
      u_fmr_host_model.toggle_trig();
      settle();
      `CHK(ramp_active, 1'b1)
      u_fmr_host_model.toggle_en();
      pulse();
      settle();
      `CHK(ramp_active, 1'b0)
      // ramp clocked by trigger edges: no step until the next pulse
      u_fmr_host_model.send_word(dev0 | 32'h4000_0000);
      u_fmr_host_model.toggle_en();
      pulse();
      settle();
      `CHK(freq_offset, 32'h0000_0000)
      pulse();
      settle();
      `CHK(freq_offset, 32'(devv[0] <<< offs[0]))
      u_fmr_host_model.toggle_en();
      pulse();
      settle();
      `CHK(ramp_active, 1'b0)
      // divider mode back to 00 once ramping is over, random timer for slot 0
      r = $random(seed);
      w = {13'h0, r[11:0], 2'h0, 5'h0d};
      u_fmr_host_model.send_word(w);
      `CHK(ramp_divider_mode, 2'h0)
      w = w | 32'h0018_0000;
      u_fmr_host_model.send_word(w);
      // second reset with the ramp stopped clears everything
      reset_n = 1'b0;
      settle();
      `CHK(ramp_divider_mode, 2'h0)
      `CHK(fixed_word_ok, 1'b0)
      reset_n = 1'b1;
      settle();
      end_sim();
   end
endmodule
